// ==== rtl/addr_decoder_regs.svh ====
`ifndef ADDR_DECODER_REGS_SVH
`define ADDR_DECODER_REGS_SVH

// architectural region bounds
`define CODE_BASE 32'h0000_0000
`define CODE_TOP 32'h1FFF_FFFF
`define SRAM_WIN_BASE 32'h2000_0000
`define SRAM_WIN_TOP 32'h3FFF_FFFF
`define PERIPH_BASE 32'h4000_0000
`define PERIPH_TOP 32'h5FFF_FFFF
`define EXT_RAM_BASE 32'h6000_0000
`define EXT_RAM_TOP 32'h9FFF_FFFF
`define EXT_DEV_BASE 32'hA000_0000
`define EXT_DEV_TOP 32'hDFFF_FFFF
`define PPB_BASE 32'hE000_0000
`define PPB_TOP 32'hE00F_FFFF
`define DEVICE_BASE 32'hE010_0000
`define DEVICE_TOP 32'hFFFF_FFFF

// physical memories in the code region
`define VECTOR_TABLE_BASE 32'h0000_0000
`define ROM_BASE 32'h0000_0000
`define ROM_TOP 32'h0001_FFFF
`define SRAM_BASE 32'h0800_0000
`define SRAM_TOP 32'h0804_7FFF
`define APP_FLASH_BASE 32'h1000_0000
`define APP_FLASH_TOP 32'h100F_FFFF
`define AUX_FLASH_BASE 32'h1400_0000
`define AUX_FLASH_TOP 32'h1400_7FFF
`define SUP_FLASH_BASE 32'h1600_0000
`define SUP_FLASH_TOP 32'h1600_7FFF

`endif

// ==== rtl/addr_decoder_pkg.sv ====
package addr_decoder_pkg;

  // architectural region of an address
  typedef enum logic [2:0] {
    REG_CODE,
    REG_SRAM_WIN,
    REG_PERIPH,
    REG_EXT_RAM,
    REG_EXT_DEV,
    REG_PPB,
    REG_DEVICE
  } region_t;

  // physical target selected for an access
  typedef enum logic [3:0] {
    TGT_NONE,
    TGT_BOOT_ROM,
    TGT_SRAM,
    TGT_APP_FLASH,
    TGT_AUX_FLASH,
    TGT_SUP_FLASH,
    TGT_PERIPH,
    TGT_SERIAL_MEM,
    TGT_PPB,
    TGT_DEVICE_REGS
  } target_t;

  // request from one cpu master
  typedef struct packed {
    logic valid;
    logic [31:0] addr;
    logic fetch;
  } cpu_req_t;

  // registered decode result for one master
  typedef struct packed {
    logic valid;
    logic [31:0] addr;
    region_t region;
    target_t target;
    logic exec_ok;
    logic error;
  } cpu_dec_t;

endpackage : addr_decoder_pkg

// ==== rtl/dual_cpu_address_region_decoder.sv ====
`include "addr_decoder_regs.svh"

// Overview of operation
// - both masters decode through one identical fixed address map
// - addresses up to 0x1FFF_FFFF form the code region
// - vector table sits at address zero, bottom of the code region
// - fetches allowed only from code and external ram regions
// - sram window 0x2000_0000-0x3FFF_FFFF has no memory behind it
// - 0x4000_0000-0x5FFF_FFFF holds peripherals, no fetch, no bit-band alias
// - 0x6000_0000-0x9FFF_FFFF goes to serial memory interface, fetch allowed
// - external device range 0xA000_0000-0xDFFF_FFFF is unused
// - 0xE000_0000-0xE00F_FFFF reaches core private peripheral registers
// - topmost range up to 0xFFFF_FFFF decodes to device system registers
// - boot rom of 128 KB spans zero to 0x0001_FFFF
// - on-chip sram decoded at 0x0800_0000-0x0804_7FFF in code region
// - application flash selected at 0x1000_0000-0x100F_FFFF
// - auxiliary flash sector selected at 0x1400_0000-0x1400_7FFF
// - supervisory flash sector selected at 0x1600_0000-0x1600_7FFF
// - first fetches after reset come from the boot rom
module dual_cpu_address_region_decoder (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire addr_decoder_pkg::cpu_req_t primary_cpu_core_req,
  input wire addr_decoder_pkg::cpu_req_t secondary_cpu_core_req,
  output addr_decoder_pkg::cpu_dec_t primary_cpu_core_dec,
  output addr_decoder_pkg::cpu_dec_t secondary_cpu_core_dec,
  output logic [31:0] reset_vector_addr,
  output logic boot_from_rom
);
  import addr_decoder_pkg::*;

  // classify an address into its architectural region
  function automatic region_t region_of(input logic [31:0] a);
    region_t r;
    r = REG_DEVICE;
    if (a <= `CODE_TOP) begin
      r = REG_CODE;
    end else if (a <= `SRAM_WIN_TOP) begin
      r = REG_SRAM_WIN;
    end else if (a <= `PERIPH_TOP) begin
      r = REG_PERIPH;
    end else if (a <= `EXT_RAM_TOP) begin
      r = REG_EXT_RAM;
    end else if (a <= `EXT_DEV_TOP) begin
      r = REG_EXT_DEV;
    end else if (a <= `PPB_TOP) begin
      r = REG_PPB;
    end else if (a >= `DEVICE_BASE) begin
      r = REG_DEVICE;
    end else begin
      r = REG_PPB;
    end
    return r;
  endfunction : region_of

  // select the physical target; gaps inside regions stay unmapped
  function automatic target_t target_of(input logic [31:0] a, input region_t r);
    target_t t;
    t = TGT_NONE;
    unique case (r)
      REG_CODE: begin
        if (a <= `ROM_TOP) begin
          t = TGT_BOOT_ROM;
        end else if (a >= `SRAM_BASE && a <= `SRAM_TOP) begin
          t = TGT_SRAM;
        end else if (a >= `APP_FLASH_BASE && a <= `APP_FLASH_TOP) begin
          t = TGT_APP_FLASH;
        end else if (a >= `AUX_FLASH_BASE && a <= `AUX_FLASH_TOP) begin
          t = TGT_AUX_FLASH;
        end else if (a >= `SUP_FLASH_BASE && a <= `SUP_FLASH_TOP) begin
          t = TGT_SUP_FLASH;
        end
      end
      REG_SRAM_WIN: t = TGT_NONE;
      REG_PERIPH: t = TGT_PERIPH;
      REG_EXT_RAM: t = TGT_SERIAL_MEM;
      REG_EXT_DEV: t = TGT_NONE;
      REG_PPB: t = (a <= `PPB_TOP) ? TGT_PPB : TGT_NONE;
      REG_DEVICE: t = TGT_DEVICE_REGS;
    endcase
    return t;
  endfunction : target_of

  // execute permission per region
  function automatic logic exec_of(input region_t r);
    return (r == REG_CODE) || (r == REG_EXT_RAM);
  endfunction : exec_of

  // full decode of one request
  function automatic cpu_dec_t decode(input cpu_req_t q);
    cpu_dec_t d;
    d.valid = q.valid;
    d.addr = q.addr;
    d.region = region_of(q.addr);
    d.target = target_of(q.addr, d.region);
    d.exec_ok = exec_of(d.region);
    d.error = q.valid && ((d.target == TGT_NONE) || (q.fetch && !d.exec_ok));
    return d;
  endfunction : decode

  cpu_dec_t pri_dec_d;
  cpu_dec_t sec_dec_d;
  cpu_dec_t pri_dec_q;
  cpu_dec_t sec_dec_q;
  logic boot_q;

  // same decode function for both masters
  always_comb begin
    pri_dec_d = decode(primary_cpu_core_req);
    sec_dec_d = decode(secondary_cpu_core_req);
  end

  // registered decode results
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      pri_dec_q <= '{valid: 1'b0, addr: 32'h0000_0000, region: REG_CODE,
                     target: TGT_NONE, exec_ok: 1'b0, error: 1'b0};
      sec_dec_q <= '{valid: 1'b0, addr: 32'h0000_0000, region: REG_CODE,
                     target: TGT_NONE, exec_ok: 1'b0, error: 1'b0};
    end else begin
      pri_dec_q <= pri_dec_d;
      sec_dec_q <= sec_dec_d;
    end
  end

  // boot flag: high from reset until the first fetch is decoded
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      boot_q <= 1'b1;
    end else if ((primary_cpu_core_req.valid && primary_cpu_core_req.fetch) ||
                 (secondary_cpu_core_req.valid && secondary_cpu_core_req.fetch)) begin
      boot_q <= 1'b0;
    end
  end

  assign primary_cpu_core_dec = pri_dec_q;
  assign secondary_cpu_core_dec = sec_dec_q;
  assign reset_vector_addr = `VECTOR_TABLE_BASE;
  assign boot_from_rom = boot_q;

endmodule : dual_cpu_address_region_decoder

// ==== verification/decoder_monitor.sv ====
module decoder_monitor (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire addr_decoder_pkg::cpu_req_t primary_cpu_core_req,
  input wire addr_decoder_pkg::cpu_req_t secondary_cpu_core_req,
  input wire addr_decoder_pkg::cpu_dec_t primary_cpu_core_dec,
  input wire addr_decoder_pkg::cpu_dec_t secondary_cpu_core_dec,
  input wire logic [31:0] reset_vector_addr,
  input wire logic boot_from_rom
);
  timeunit 1ns;
  timeprecision 1ps;
  import addr_decoder_pkg::*;
  cpu_req_t p;
  cpu_req_t s;
  cpu_dec_t d;
  cpu_dec_t e;
  // short aliases for the watched ports
  assign p = primary_cpu_core_req;
  assign s = secondary_cpu_core_req;
  assign d = primary_cpu_core_dec;
  assign e = secondary_cpu_core_dec;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  valid_copy_a: assert property (p.valid |=> d.valid && d.addr == $past(p.addr)) else $error("copy wrong");
  code_region_a: assert property (p.valid && !p.addr[31:29] |=> d.region == REG_CODE) else $error("code");
  rom_target_a: assert property (p.valid && p.addr <= 32'h0001_FFFF |=> d.target == TGT_BOOT_ROM) else $error("rom");
  sram_gap_a: assert property (p.valid && p.addr[31:29] == 3'h1 |=> d.error) else $error("sram window");
  periph_fetch_a: assert property (p.valid && p.fetch && p.addr[31:29] == 3'h2 |=> d.error) else $error("periph");
  ext_ram_a: assert property (p.valid && p.addr >= 32'h6000_0000 && p.addr <= 32'h9FFF_FFFF |=>
    d.exec_ok && !d.error && d.target == TGT_SERIAL_MEM) else $error("xram");
  ppb_route_a: assert property (p.valid && p.addr[31:20] == 12'hE00 |=> d.target == TGT_PPB) else $error("ppb");
  same_map_a: assert property (p == s |=> d == e) else $error("maps differ");
  vector_zero_a: assert property (reset_vector_addr == 32'h0000_0000) else $error("vector");
  boot_hold_a: assert property (boot_from_rom && !(p.valid && p.fetch) && !(s.valid && s.fetch) |=> boot_from_rom)
    else $error("boot lost");
  boot_drop_a: assert property (p.valid && p.fetch |=> !boot_from_rom) else $error("boot kept");
endmodule : decoder_monitor

bind dual_cpu_address_region_decoder decoder_monitor mon (.core_clk(core_clk), .arst_n(arst_n),
  .primary_cpu_core_req(primary_cpu_core_req), .secondary_cpu_core_req(secondary_cpu_core_req),
  .primary_cpu_core_dec(primary_cpu_core_dec), .secondary_cpu_core_dec(secondary_cpu_core_dec),
  .reset_vector_addr(reset_vector_addr), .boot_from_rom(boot_from_rom));

// ==== verification/cpu_master_model.sv ====
module cpu_master_model (
  input wire logic core_clk,
  input wire logic next_valid,
  input wire logic [31:0] next_addr,
  input wire logic next_fetch,
  output addr_decoder_pkg::cpu_req_t req
);
  timeunit 1ns;
  timeprecision 1ps;
  initial req = '0;
  // request moves at the falling edge; an idle address toggles
  always @(negedge core_clk) begin
    req.valid <= next_valid;
    req.addr <= next_valid ? next_addr : ~req.addr;
    req.fetch <= next_valid & next_fetch;
  end
endmodule : cpu_master_model

// ==== verification/dual_cpu_address_region_decoder_bench.sv ====
`include "addr_decoder_regs.svh"
module dual_cpu_address_region_decoder_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import addr_decoder_pkg::*;
  logic core_clk = 0;
  logic arst_n = 0;
  logic [31:0] pa = 0;
  logic [31:0] sa = 0;
  logic pv = 0;
  logic pf = 0;
  logic sv = 0;
  logic sf = 0;
  cpu_req_t preq;
  cpu_req_t sreq;
  cpu_dec_t pdec;
  cpu_dec_t sdec;
  logic [31:0] rv;
  logic boot;
  int error_cnt = 0;
  int checked = 0;
  int cyc = 0;
  int seed = 32'h243a;
  logic [31:0] corner [14] = '{`ROM_BASE, `ROM_TOP, `SRAM_BASE, `SRAM_TOP, `SRAM_TOP + 32'h1, `APP_FLASH_TOP,
    `AUX_FLASH_TOP, `SUP_FLASH_BASE, `CODE_TOP, `PERIPH_BASE, `EXT_RAM_TOP, `EXT_DEV_BASE, `PPB_TOP, `DEVICE_BASE};
  always #5 core_clk = ~core_clk;
  cpu_master_model pm (.core_clk(core_clk), .next_valid(pv), .next_addr(pa), .next_fetch(pf), .req(preq));
  cpu_master_model sm (.core_clk(core_clk), .next_valid(sv), .next_addr(sa), .next_fetch(sf), .req(sreq));
  dual_cpu_address_region_decoder uut (.core_clk(core_clk), .arst_n(arst_n), .primary_cpu_core_req(preq),
    .secondary_cpu_core_req(sreq), .primary_cpu_core_dec(pdec), .secondary_cpu_core_dec(sdec),
    .reset_vector_addr(rv), .boot_from_rom(boot));
  function automatic cpu_dec_t exp_dec(logic [31:0] a, logic f);
    cpu_dec_t e;
    e.valid = 1'b1;
    e.addr = a;
    e.region = a <= `CODE_TOP ? REG_CODE : a <= `SRAM_WIN_TOP ? REG_SRAM_WIN : a <= `PERIPH_TOP ? REG_PERIPH :
      a <= `EXT_RAM_TOP ? REG_EXT_RAM : a <= `EXT_DEV_TOP ? REG_EXT_DEV : a <= `PPB_TOP ? REG_PPB : REG_DEVICE;
    e.target = a <= `ROM_TOP ? TGT_BOOT_ROM : a inside {[`SRAM_BASE:`SRAM_TOP]} ? TGT_SRAM :
      a inside {[`APP_FLASH_BASE:`APP_FLASH_TOP]} ? TGT_APP_FLASH : a inside {[`AUX_FLASH_BASE:`AUX_FLASH_TOP]} ?
      TGT_AUX_FLASH : a inside {[`SUP_FLASH_BASE:`SUP_FLASH_TOP]} ? TGT_SUP_FLASH :
      e.region inside {REG_CODE, REG_SRAM_WIN, REG_EXT_DEV} ? TGT_NONE : e.region == REG_PERIPH ? TGT_PERIPH :
      e.region == REG_EXT_RAM ? TGT_SERIAL_MEM : e.region == REG_PPB ? TGT_PPB : TGT_DEVICE_REGS;
    e.exec_ok = e.region inside {REG_CODE, REG_EXT_RAM};
    e.error = e.target == TGT_NONE || (f && !e.exec_ok);
    return e;
  endfunction : exp_dec
  task chk(string n, logic [41:0] e, logic [41:0] g);
    checked++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task complete_run;
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : complete_run
  // both masters request together, decode checked one edge later
  task issue(logic [31:0] a, logic f, logic [31:0] b, logic g);
    @(posedge core_clk);
    {pv, pa, pf, sv, sa, sf} <= {1'b1, a, f, 1'b1, b, g};
    @(posedge core_clk);
    #1;
    chk("primary", exp_dec(a, f), pdec);
    chk("secondary", exp_dec(b, g), sdec);
  endtask : issue
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 3000) begin
      error_cnt++;
      complete_run();
    end
  end
  initial begin
    repeat (6) @(posedge core_clk);
    @(negedge core_clk) arst_n = 1;
    chk("vector", 42'h0, 42'(rv));
    for (int i = 0; i < 14; i++) issue(corner[i], 1'b0, corner[i], 1'b0);
    chk("boot", 42'h1, 42'(boot));
    for (int i = 0; i < 14; i++) issue(corner[i], 1'b1, corner[i], 1'b1);
    chk("boot", 42'h0, 42'(boot));
    // mid-run reset: boot flag and decode registers return to their reset state
    @(negedge core_clk) arst_n = 0;
    @(negedge core_clk);
    chk("boot", 42'h1, 42'(boot));
    chk("reset", 42'h0, pdec);
    arst_n = 1;
    repeat (200) issue($random(seed), 1'($random(seed)), {4'h1, 28'($random(seed))}, 1'($random(seed)));
    complete_run();
  end
endmodule : dual_cpu_address_region_decoder_bench
